// [core/power_recovery_start_mode.sv]
// Power-recovery start-mode sequencer with register port and retention store.
//
// Chosen here: strobed register access and the placing of the registers.
module power_recovery_start_mode
#(
	parameter int OUTAGE_LIMIT = recovery_pkg::OUTAGE_CYCLES
)
(
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic supply_ok_i,
	input wire recovery_pkg::word_t pv_i,
	input wire recovery_pkg::word_t sv_i,
	input wire recovery_pkg::word_t ctrl_result_i,
	input wire logic ctrl_valid_i,
	input wire logic motor_open_req_i,
	input wire logic motor_close_req_i,
	input wire recovery_pkg::addr_t reg_addr_i,
	input wire recovery_pkg::word_t reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output recovery_pkg::word_t reg_rdata_o,
	output recovery_pkg::word_t primary_manipulated_output_o,
	output logic motor_open_o,
	output logic motor_close_o,
	output logic run_o,
	output logic auto_o,
	output logic recovering_o
);
	import recovery_pkg::*;

	typedef enum logic [2:0] {S_RUN, S_SHORT, S_LONG, S_FETCH, S_APPLY} state_e;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic in_band(input word_t pv, input word_t sv, input word_t band);
		word_t diff;
		diff = (pv >= sv) ? (pv - sv) : (sv - pv);
		return diff <= band;
	endfunction : in_band

	function automatic logic [1:0] valve_drive(input logic [1:0] code);
		return {code == VALVE_OPEN, code == VALVE_CLOSE};
	endfunction : valve_drive

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	state_e state_q, state_d;
	logic sup_meta_q, sup_s_q;
	logic [31:0] cnt_q;
	logic [1:0] mode_q, valve_q, motor_q, motor_d;
	logic run_q, auto_q, atune_q, nofbr_q, hold_prev_q, inhibit_q, recovered_q, mem_sel_q;
	logic [1:0] last_mode_q;
	word_t band_q, low_q, stop_q, manual_q, out_q, out_d, prev_out_q, rdata_q, mem_rdata;
	logic wr_ctrl, wr_band, wr_low, wr_stop, wr_man, wr_sts, apply, band_hit, prev_auto, prev_run;
	logic [1:0] eff_mode;
	word_t rd_mux, apply_out;

	// ----------------------------------------------------------------
	// Supply pin synchroniser and outage timer
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			sup_meta_q <= 1'b1;
			sup_s_q <= 1'b1;
		end
		else
		begin
			sup_meta_q <= supply_ok_i;
			sup_s_q <= sup_meta_q;
		end
	end

	// The timer only runs while the supply is missing, so it times the outage itself.
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			cnt_q <= 32'h0000_0000;
		else if (state_q == S_SHORT)
			cnt_q <= cnt_q + 32'h0000_0001;
		else
			cnt_q <= 32'h0000_0000;
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// A dip that ends before the limit returns straight to running with nothing changed.
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			S_RUN: if (!sup_s_q) state_d = S_SHORT;
			S_SHORT:
			begin
				if (sup_s_q)
					state_d = S_RUN;
				else if (cnt_q == 32'(OUTAGE_LIMIT - 1))
					state_d = S_LONG;
			end
			S_LONG: if (sup_s_q) state_d = S_FETCH;
			S_FETCH: state_d = S_APPLY;
			S_APPLY: state_d = S_RUN;
			default: state_d = S_RUN;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			state_q <= S_RUN;
		else
			state_q <= state_d;
	end

	// ----------------------------------------------------------------
	// Start-mode selection
	// ----------------------------------------------------------------
	// The band check outranks the autotune promotion: a process already at set value starts hot.
	assign apply = (state_q == S_APPLY);
	assign prev_auto = mem_rdata[0];
	assign prev_run = mem_rdata[1];
	assign band_hit = (band_q != 16'h0000) && in_band(pv_i, sv_i, band_q);
	assign eff_mode = band_hit ? START_HOT1 :
		((mode_q == START_HOT1) && atune_q) ? START_HOT2 : mode_q;
	assign apply_out = (eff_mode == START_HOT1) ? prev_out_q :
		(eff_mode == START_STOP) ? stop_q :
		((eff_mode == START_HOT2) && prev_auto) ? ctrl_result_i : low_q;

	// ----------------------------------------------------------------
	// Register write decode
	// ----------------------------------------------------------------
	assign wr_ctrl = reg_wr_i && (reg_addr_i == REG_CONTROL);
	assign wr_band = reg_wr_i && (reg_addr_i == REG_BAND);
	assign wr_low = reg_wr_i && (reg_addr_i == REG_LOW_LIMIT);
	assign wr_stop = reg_wr_i && (reg_addr_i == REG_STOP_MV);
	assign wr_man = reg_wr_i && (reg_addr_i == REG_MANUAL_MV);
	assign wr_sts = reg_wr_i && (reg_addr_i == REG_STATUS);

	// Configuration registers.
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			mode_q <= MODE_RST;
			atune_q <= 1'b0;
			nofbr_q <= 1'b0;
			valve_q <= VALVE_HOLD;
			band_q <= BAND_RST;
			low_q <= LOW_RST;
			stop_q <= STOP_RST;
		end
		else
		begin
			if (wr_ctrl)
			begin
				mode_q <= reg_wdata_i[CTL_MODE_LSB +: 2];
				atune_q <= reg_wdata_i[CTL_ATUNE];
				nofbr_q <= reg_wdata_i[CTL_NOFBR];
				valve_q <= reg_wdata_i[CTL_VALVE_LSB +: 2];
			end
			if (wr_band)
				band_q <= reg_wdata_i;
			if (wr_low)
				low_q <= reg_wdata_i;
			if (wr_stop)
				stop_q <= reg_wdata_i;
		end
	end

	// Run and auto state; recovery takes precedence over a software write in the same cycle.
	// Stopping never touches the auto bit, so a later run resumes the pre-outage mode.
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			run_q <= 1'b1;
			auto_q <= 1'b1;
			manual_q <= MANUAL_RST;
			hold_prev_q <= 1'b0;
			inhibit_q <= 1'b0;
			last_mode_q <= START_HOT1;
		end
		else if (apply)
		begin
			run_q <= (eff_mode == START_STOP) ? 1'b0 : prev_run;
			auto_q <= (eff_mode == START_COLD) ? 1'b0 : prev_auto;
			manual_q <= (eff_mode == START_HOT1) ? prev_out_q : low_q;
			hold_prev_q <= (eff_mode == START_HOT1);
			inhibit_q <= nofbr_q && ((eff_mode == START_COLD) || ((eff_mode == START_HOT2) && !prev_auto));
			last_mode_q <= eff_mode;
		end
		else
		begin
			if (wr_ctrl)
			begin
				run_q <= reg_wdata_i[CTL_RUN];
				auto_q <= reg_wdata_i[CTL_AUTO];
			end
			if (wr_man)
				manual_q <= reg_wdata_i;
			if (ctrl_valid_i)
				hold_prev_q <= 1'b0;
			if (wr_man || wr_ctrl)
				inhibit_q <= 1'b0;
		end
	end

	// Recovered flag: the apply event wins over a write-one clear in the same cycle.
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			recovered_q <= 1'b0;
		else if (apply)
			recovered_q <= 1'b1;
		else if (wr_sts && reg_wdata_i[STS_RECOVERED])
			recovered_q <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Output and motor drive
	// ----------------------------------------------------------------
	// In a short dip everything is frozen; during a long outage the outputs drop to zero.
	always_comb
	begin
		out_d = 16'h0000;
		motor_d = 2'b00;
		case (state_q)
			S_SHORT:
			begin
				out_d = out_q;
				motor_d = motor_q;
			end
			S_APPLY: out_d = apply_out;
			S_RUN:
			begin
				if (!run_q)
					out_d = stop_q;
				else if (!auto_q)
					out_d = manual_q;
				else
					out_d = hold_prev_q ? out_q : ctrl_result_i;
				if (nofbr_q && !run_q)
					motor_d = valve_drive(valve_q);
				else if (run_q && !inhibit_q)
					motor_d = {motor_open_req_i, motor_close_req_i};
			end
			default:
			begin
				out_d = 16'h0000;
				motor_d = 2'b00;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			out_q <= 16'h0000;
			motor_q <= 2'b00;
			prev_out_q <= 16'h0000;
		end
		else
		begin
			out_q <= out_d;
			motor_q <= motor_d;
			if (state_q == S_FETCH)
				prev_out_q <= mem_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Retention store
	// ----------------------------------------------------------------
	// Words are refreshed alternately while running; nothing is written once the supply dips.
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			mem_sel_q <= MEM_OUT;
		else
			mem_sel_q <= ~mem_sel_q;
	end

	retain_store u_store
	(
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.we_i(state_q == S_RUN),
		.waddr_i(mem_sel_q),
		.wdata_i(mem_sel_q ? {14'h0000, run_q, auto_q} : out_q),
		.raddr_i(state_q == S_FETCH ? MEM_FLAGS : MEM_OUT),
		.rdata_o(mem_rdata)
	);

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	assign rd_mux = (reg_addr_i == REG_CONTROL) ?
		{8'h00, valve_q, nofbr_q, atune_q, auto_q, run_q, mode_q} :
		(reg_addr_i == REG_BAND) ? band_q :
		(reg_addr_i == REG_LOW_LIMIT) ? low_q :
		(reg_addr_i == REG_STOP_MV) ? stop_q :
		(reg_addr_i == REG_MANUAL_MV) ? manual_q :
		(reg_addr_i == REG_STATUS) ? {9'h000, recovered_q, last_mode_q, inhibit_q, state_q != S_RUN, auto_q, run_q} :
		(reg_addr_i == REG_OUTPUT) ? out_q : 16'h0000;

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			rdata_q <= 16'h0000;
		else
			rdata_q <= reg_rd_i ? rd_mux : 16'h0000;
	end

	assign reg_rdata_o = rdata_q;
	assign primary_manipulated_output_o = out_q;
	assign motor_open_o = motor_q[1];
	assign motor_close_o = motor_q[0];
	assign run_o = run_q;
	assign auto_o = auto_q;
	assign recovering_o = (state_q != S_RUN);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	short_dip_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(state_q == S_SHORT && sup_s_q) |=> (state_q == S_RUN) && $stable(out_q))
		else $error("Short dip did not resume unchanged.");
	long_outage_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(state_q == S_SHORT && !sup_s_q && cnt_q == 32'(OUTAGE_LIMIT - 1)) |=> state_q == S_LONG)
		else $error("Long outage not detected at the limit.");
	hot_one_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(apply && eff_mode == START_HOT1) |=> out_q == $past(prev_out_q) && auto_q == $past(mem_rdata[0]))
		else $error("Hot start one did not restore output and mode.");
	hot_two_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(apply && eff_mode == START_HOT2 && !mem_rdata[0]) |=> out_q == $past(low_q) && !auto_q)
		else $error("Hot start two manual not at low limit.");
	cold_start_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(apply && eff_mode == START_COLD && nofbr_q) |=> !auto_q && out_q == $past(low_q) ##1 motor_q == 2'b00)
		else $error("Cold start not manual at low limit without motor drive.");
	stop_start_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(apply && eff_mode == START_STOP) |=> !run_q && out_q == $past(stop_q) && auto_q == $past(mem_rdata[0]))
		else $error("Stopped start did not come up stopped.");
	stop_valve_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(state_q == S_RUN && !run_q && nofbr_q) |=> motor_q == valve_drive($past(valve_q)))
		else $error("Motor drive at stop ignores valve setting.");
	atune_promote_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(apply && !band_hit && mode_q == START_HOT1 && atune_q) |=> hold_prev_q == 1'b0 && last_mode_q == START_HOT2)
		else $error("Autotune did not force hot start two.");
	band_hot_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(apply && band_q != 16'h0000 && in_band(pv_i, sv_i, band_q)) |=> last_mode_q == START_HOT1 && hold_prev_q)
		else $error("Band hit did not force hot start one.");
	retain_flags_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(state_q == S_RUN && mem_sel_q == MEM_FLAGS) |=> u_store.mem_q[1] == {14'h0000, $past(run_q), $past(auto_q)})
		else $error("Retention store missed the run and mode flags.");

endmodule : power_recovery_start_mode

// [inc/recovery_pkg.sv]
// Package holding the constants and types of the power-recovery start-mode block.
package recovery_pkg;

	// ----------------------------------------------------------------
	// Data widths and timing
	// ----------------------------------------------------------------
	typedef logic [15:0] word_t;
	typedef logic [7:0] addr_t;
	localparam int CLK_HZ = 100_000_000;
	localparam int OUTAGE_MS = 20;
	localparam int OUTAGE_CYCLES = (CLK_HZ / 1000) * OUTAGE_MS;

	// ----------------------------------------------------------------
	// Start-mode codes and valve-at-stop codes
	// ----------------------------------------------------------------
	localparam logic [1:0] START_HOT1 = 2'h0;
	localparam logic [1:0] START_HOT2 = 2'h1;
	localparam logic [1:0] START_COLD = 2'h2;
	localparam logic [1:0] START_STOP = 2'h3;
	localparam logic [1:0] VALVE_HOLD = 2'h0;
	localparam logic [1:0] VALVE_OPEN = 2'h1;
	localparam logic [1:0] VALVE_CLOSE = 2'h2;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam addr_t REG_CONTROL = 8'h00;
	localparam addr_t REG_BAND = 8'h04;
	localparam addr_t REG_LOW_LIMIT = 8'h08;
	localparam addr_t REG_STOP_MV = 8'h0c;
	localparam addr_t REG_MANUAL_MV = 8'h10;
	localparam addr_t REG_STATUS = 8'h14;
	localparam addr_t REG_OUTPUT = 8'h18;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTL_MODE_LSB = 0;
	localparam int CTL_RUN = 2;
	localparam int CTL_AUTO = 3;
	localparam int CTL_ATUNE = 4;
	localparam int CTL_NOFBR = 5;
	localparam int CTL_VALVE_LSB = 6;
	localparam int STS_RECOVERED = 6;

	// ----------------------------------------------------------------
	// Reset values and retention word layout
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_RST = START_HOT1;
	localparam word_t BAND_RST = 16'h0000;
	localparam word_t LOW_RST = 16'h0000;
	localparam word_t STOP_RST = 16'h0000;
	localparam word_t MANUAL_RST = 16'h0000;
	localparam logic MEM_OUT = 1'b0;
	localparam logic MEM_FLAGS = 1'b1;

endpackage : recovery_pkg

// [core/retain_store.sv]
// Two-word retention store for the pre-interruption output and mode flags.
module retain_store
(
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic we_i,
	input wire logic waddr_i,
	input wire recovery_pkg::word_t wdata_i,
	input wire logic raddr_i,
	output recovery_pkg::word_t rdata_o
);
	import recovery_pkg::*;

	word_t mem_q [2];
	word_t rdata_q;

	// Each word is only written while the supply is good, so it keeps its contents across an outage.
	for (genvar i = 0; i < 2; i++)
	begin : g_word
		always_ff @(posedge core_clk_i or negedge reset_n_i)
		begin
			if (!reset_n_i)
				mem_q[i] <= 16'h0000;
			else if (we_i && (waddr_i == 1'(i)))
				mem_q[i] <= wdata_i;
		end
	end

	// Registered read port.
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			rdata_q <= 16'h0000;
		else
			rdata_q <= mem_q[raddr_i];
	end

	assign rdata_o = rdata_q;

endmodule : retain_store

// [verif/process_stage_model.sv]
// Behavioural model of the output stage and final control element at the far side of the block.
module process_stage_model
#(
	parameter recovery_pkg::word_t RESULT = 16'h0055
)
(
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire recovery_pkg::word_t mv_i,
	input wire logic open_i,
	input wire logic close_i,
	input wire recovery_pkg::word_t pv_target_i,
	output recovery_pkg::word_t pv_o,
	output recovery_pkg::word_t result_o,
	output logic valid_o,
	output logic open_req_o,
	output logic close_req_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import recovery_pkg::*;

	word_t pos_q;

	// The valve moves one step a cycle while driven, so requests keep chasing the output value.
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			pos_q <= 16'h0000;
			pv_o <= 16'h0000;
			valid_o <= 1'b0;
		end
		else
		begin
			pv_o <= pv_target_i;
			valid_o <= ~valid_o;
			if (open_i)
				pos_q <= pos_q + 16'h0001;
			else if (close_i)
				pos_q <= pos_q - 16'h0001;
		end
	end

	// Control result is fixed so that every automatic start has one known value.
	assign result_o = RESULT;
	assign open_req_o = pos_q < mv_i;
	assign close_req_o = pos_q > mv_i;

endmodule : process_stage_model

// [verif/test_power_recovery_start_mode.sv]
// Self-checking testbench of the power-recovery start-mode block.
module test_power_recovery_start_mode;
	timeunit 1ns;
	timeprecision 1ps;
	import recovery_pkg::*;

	typedef struct packed {word_t ctrl; word_t band; word_t pv; logic run; logic auto; word_t out; logic [1:0] mode;} row_s;

	logic core_clk_i;
	logic reset_n_i = 1'b0;
	logic supply_ok_i = 1'b1;
	word_t pv_i, ctrl_result_i, reg_rdata_o, primary_manipulated_output_o;
	word_t sv_i = 16'h0100;
	word_t pv_target = 16'h0100;
	word_t reg_wdata_i = 16'h0000;
	addr_t reg_addr_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic ctrl_valid_i, motor_open_req_i, motor_close_req_i;
	logic motor_open_o, motor_close_o, run_o, auto_o, recovering_o;
	int n_fail = 0;
	int n_compared = 0;
	int cycles = 0;
	// Outage limit of the instance, kept short so that long outages cost few cycles.
	localparam int LIMIT = 20;
	word_t d;
	word_t mv_codes [3] = '{16'h0067, 16'h00a7, 16'h0027};
	word_t valve_exp [3] = '{16'h0002, 16'h0001, 16'h0000};
	row_s rows [11] = '{
		'{16'h0004, 16'h0000, 16'h0100, 1'b1, 1'b0, 16'h0033, 2'h0},
		'{16'h000c, 16'h0000, 16'h0100, 1'b1, 1'b1, 16'h0055, 2'h0},
		'{16'h0005, 16'h0000, 16'h0100, 1'b1, 1'b0, 16'h0011, 2'h1},
		'{16'h000d, 16'h0000, 16'h0100, 1'b1, 1'b1, 16'h0055, 2'h1},
		'{16'h000e, 16'h0000, 16'h0100, 1'b1, 1'b0, 16'h0011, 2'h2},
		'{16'h000f, 16'h0000, 16'h0100, 1'b0, 1'b1, 16'h0022, 2'h3},
		'{16'h0014, 16'h0000, 16'h0100, 1'b1, 1'b0, 16'h0011, 2'h1},
		'{16'h0005, 16'h0005, 16'h0103, 1'b1, 1'b0, 16'h0033, 2'h0},
		'{16'h0005, 16'h0005, 16'h0106, 1'b1, 1'b0, 16'h0011, 2'h1},
		'{16'h0014, 16'h0005, 16'h00fb, 1'b1, 1'b0, 16'h0033, 2'h0},
		'{16'h0007, 16'h0000, 16'h0100, 1'b0, 1'b0, 16'h0022, 2'h3}};

	power_recovery_start_mode #(.OUTAGE_LIMIT(LIMIT)) DUT (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
		.supply_ok_i(supply_ok_i), .pv_i(pv_i), .sv_i(sv_i), .ctrl_result_i(ctrl_result_i),
		.ctrl_valid_i(ctrl_valid_i), .motor_open_req_i(motor_open_req_i), .motor_close_req_i(motor_close_req_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .primary_manipulated_output_o(primary_manipulated_output_o),
		.motor_open_o(motor_open_o), .motor_close_o(motor_close_o), .run_o(run_o), .auto_o(auto_o),
		.recovering_o(recovering_o));

	process_stage_model model (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
		.mv_i(primary_manipulated_output_o), .open_i(motor_open_o), .close_i(motor_close_o),
		.pv_target_i(pv_target), .pv_o(pv_i), .result_o(ctrl_result_i), .valid_o(ctrl_valid_i),
		.open_req_o(motor_open_req_i), .close_req_o(motor_close_req_i));

	// ----------------------------------------------------------------
	// Clock, timeout and verdict
	// ----------------------------------------------------------------
	initial
	begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end

	// A hang anywhere ends the run as a failure instead of running forever.
	always @(posedge core_clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			n_fail++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("Compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input word_t got, input word_t exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// ----------------------------------------------------------------
	// Register port and supply tasks
	// ----------------------------------------------------------------
	task automatic reg_write(input addr_t a, input word_t v);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask : reg_write

	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic reg_read(input addr_t a, output word_t v);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		v = reg_rdata_o;
	endtask : reg_read

	task automatic outage(input int n);
		int w;
		@(posedge core_clk_i);
		supply_ok_i <= 1'b0;
		repeat (n) @(posedge core_clk_i);
		supply_ok_i <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		#1;
		w = 0;
		while (recovering_o !== 1'b0 && w < 50)
		begin
			@(posedge core_clk_i);
			#1;
			w++;
		end
		// A long outage is still in its apply cycle here; a short dip is already running again.
		chk(16'(w), (n > LIMIT) ? 16'h0001 : 16'h0000, "recovery time");
		repeat (3) @(posedge core_clk_i);
		#1;
	endtask : outage

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		reg_read(REG_CONTROL, d);
		chk(d, 16'h000c, "control reset");
		reg_read(REG_BAND, d);
		chk(d, 16'h0000, "band reset");
		reg_read(8'h1c, d);
		chk(d, 16'h0000, "unmapped read");
		reg_write(REG_LOW_LIMIT, 16'h0011);
		reg_write(REG_STOP_MV, 16'h0022);
		reg_write(REG_MANUAL_MV, 16'h0033);
		$display("Reset test done");
		// Each row sets a start mode, runs, then suffers a long outage.
		foreach (rows[i])
		begin
			reg_write(REG_BAND, rows[i].band);
			pv_target <= rows[i].pv;
			reg_write(REG_MANUAL_MV, 16'h0033);
			reg_write(REG_CONTROL, rows[i].ctrl);
			reg_write(REG_STATUS, 16'h0040);
			repeat (20) @(posedge core_clk_i);
			outage(40);
			chk(primary_manipulated_output_o, rows[i].out, "output");
			chk({14'h0, run_o, auto_o}, {14'h0, rows[i].run, rows[i].auto}, "run auto");
			reg_read(REG_STATUS, d);
			chk(d & 16'h0073, {9'h0, 1'b1, rows[i].mode, 2'b00, rows[i].auto, rows[i].run}, "status");
			$display("Row %0d done", i);
		end
		// Going back to run after a stopped start keeps the manual mode held before the outage.
		reg_read(REG_CONTROL, d);
		chk(d & 16'h000c, 16'h0000, "stopped control");
		reg_write(REG_CONTROL, d | 16'h0004);
		@(posedge core_clk_i);
		#1;
		chk({14'h0, run_o, auto_o}, 16'h0002, "run restore");
		$display("Restore test done");
		// A dip shorter than the limit must leave everything as it was.
		reg_write(REG_STATUS, 16'h0040);
		reg_write(REG_MANUAL_MV, 16'h0033);
		repeat (5) @(posedge core_clk_i);
		outage(10);
		chk(primary_manipulated_output_o, 16'h0033, "dip output");
		reg_read(REG_OUTPUT, d);
		chk(d, 16'h0033, "dip output register");
		reg_read(REG_STATUS, d);
		chk(d & 16'h0043, 16'h0001, "dip status");
		$display("Dip test done");
		// Without position feedback, cold start holds the motor until a manual value or a control word is written.
		reg_write(REG_CONTROL, 16'h0026);
		outage(40);
		chk({14'h0, motor_open_o, motor_close_o}, 16'h0000, "cold motors");
		reg_read(REG_STATUS, d);
		chk(d & 16'h0008, 16'h0008, "motor inhibit");
		reg_write(REG_MANUAL_MV, 16'h00ff);
		repeat (3) @(posedge core_clk_i);
		#1;
		chk({15'h0, motor_open_o}, 16'h0001, "motor release");
		foreach (mv_codes[k])
		begin
			reg_write(REG_CONTROL, mv_codes[k]);
			outage(40);
			chk({14'h0, motor_open_o, motor_close_o}, valve_exp[k], "valve at stop");
		end
		$display("Motor test done");
		// A second reset in mid-run must bring back every default before the first edge after release.
		@(posedge core_clk_i);
		reset_n_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		#1;
		chk({13'h0, run_o, auto_o, recovering_o}, 16'h0006, "reset state");
		chk(primary_manipulated_output_o, 16'h0000, "reset output");
		reg_read(REG_CONTROL, d);
		chk(d, 16'h000c, "reset control");
		$display("Mid-run reset test done");
		end_of_test();
	end

endmodule : test_power_recovery_start_mode
